// ==== verilog/amc_pkg.sv ====
// Purpose: Constants shared by the converter mode control logic
// Assumes: Peripheral clock is clk_sys at 100 MHz
// Notes:   Offsets are byte addresses on the internal special-register bus
`default_nettype none
package amc_pkg;
  localparam logic [15:0] MODE_ADDR    = 16'hff80;
  localparam logic [15:0] CHAN_ADDR    = 16'hff81;
  localparam logic [15:0] RES_LO_ADDR  = 16'hff18;
  localparam logic [15:0] RES_HI_ADDR  = 16'hff19;
  localparam logic [15:0] RES_BYTE_ADDR = 16'hff1a;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CHAN_RESET   = 8'h00;
  localparam int          RUN_POS      = 7;
  localparam int          CODE_LSB     = 3;
  localparam int          ENA_POS      = 0;
  localparam logic [7:0]  MODE_MASK    = 8'hb9;
  localparam logic [7:0]  CHAN_MASK    = 8'h03;
  localparam int          RES_BITS     = 10;
  localparam int          CNT_W        = 8;

  typedef enum logic [1:0] {
    AMC_STOP = 2'b00,
    AMC_WAIT = 2'b01,
    AMC_CONV = 2'b10
  } amc_state_t;

  // Sampling and total cycles per time code
  function automatic logic [CNT_W-1:0] amc_samp(input logic [2:0] code);
    case (code)
      3'h0: amc_samp = 8'd12;
      3'h1: amc_samp = 8'd24;
      3'h2: amc_samp = 8'd48;
      3'h3: amc_samp = 8'd88;
      3'h4: amc_samp = 8'd24;
      3'h5: amc_samp = 8'd48;
      3'h6: amc_samp = 8'd96;
      default: amc_samp = 8'd176;
    endcase
  endfunction : amc_samp

  function automatic logic [CNT_W-1:0] amc_total(input logic [2:0] code);
    case (code)
      3'h0: amc_total = 8'd36;
      3'h1: amc_total = 8'd48;
      3'h2: amc_total = 8'd72;
      3'h3: amc_total = 8'd112;
      3'h4: amc_total = 8'd72;
      3'h5: amc_total = 8'd96;
      3'h6: amc_total = 8'd144;
      default: amc_total = 8'd224;
    endcase
  endfunction : amc_total
endpackage : amc_pkg
`default_nettype wire

// ==== verilog/amc_sar.sv ====
// Purpose: Ten-bit successive approximation walk, one bit per step enable
// Assumes: Comparator answer is already synchronous to clk_sys
// Notes:   Zeroed by clear, which wins over begin_walk; a new walk overrides any walk in progress
`default_nettype none
module amc_sar #(
  parameter int BITS = 10
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // Control
  input  wire logic            clear,
  input  wire logic            begin_walk,
  input  wire logic            step,
  input  wire logic            cmp_high,
  // Trial value and result
  output logic [BITS-1:0]      trial,
  output logic                 walk_done
);
  // Walk needs at least two bits, and the trial bus stays within a halfword
  if (BITS < 2 || BITS > 16) begin : g_bad_bits
    $error("amc_sar: BITS out of range");
  end

  logic [BITS-1:0] sar_bit;
  logic [BITS-1:0] next_trial;
  logic [BITS-1:0] next_sar_bit;
  logic            next_walk_done;

  always_comb begin
    next_trial     = trial;
    next_sar_bit   = sar_bit;
    next_walk_done = 1'b0;
    if (clear) begin
      next_trial   = '0;
      next_sar_bit = '0;
    end else if (begin_walk) begin
      next_sar_bit = {1'b1, {(BITS-1){1'b0}}};
      next_trial   = {1'b1, {(BITS-1){1'b0}}};
    end else if (step && sar_bit != '0) begin
      // Keep or drop the bit under test, then try the next one down
      if (!cmp_high) next_trial = trial & ~sar_bit;
      next_sar_bit = sar_bit >> 1;
      next_trial   = (cmp_high ? trial : (trial & ~sar_bit)) | (sar_bit >> 1);
      if (sar_bit[0]) next_walk_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trial     <= '0;
      sar_bit   <= '0;
      walk_done <= 1'b0;
    end else begin
      trial     <= next_trial;
      sar_bit   <= next_sar_bit;
      walk_done <= next_walk_done;
    end
  end
endmodule : amc_sar
`default_nettype wire

// ==== verilog/amc_ctrl.sv ====
// Purpose: Mode and channel registers, sampling and conversion sequencing
// Assumes: Byte or single-bit writes on an 8-bit special-register bus
// Notes:   Analog sample, hold and comparator circuits sit outside
`default_nettype none
module amc_ctrl (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Special-register bus
  input  wire logic [15:0]             reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_bit_wr,
  input  wire logic [2:0]              reg_bit_sel,
  input  wire logic [7:0]              reg_wdata,
  output logic [7:0]                   reg_rdata,
  // Analog front end
  input  wire logic                    cmp_high,
  output logic [amc_pkg::RES_BITS-1:0] dac_trial,
  output logic                         sample_hold,
  output logic                         comparator_on,
  output logic [1:0]                   channel_code,
  // Results and event
  output logic [15:0]                  result_wide,
  output logic [7:0]                   result_upper_byte,
  output logic                         conversion_done_request,
  output amc_pkg::amc_state_t          op_state
);
  import amc_pkg::*;

  logic [7:0]     converter_mode_control;
  logic [7:0]     input_channel_select;
  logic [7:0]     next_mode;
  logic [7:0]     next_chan;
  logic           cmp_meta;
  logic           cmp_sync;
  logic [CNT_W-1:0] cyc;
  logic [CNT_W-1:0] next_cyc;
  logic           active;
  logic           next_active;
  logic [15:0]    next_wide;
  logic [7:0]     next_upper;
  logic           next_done_req;
  logic           reg_touch;
  logic           walk_start;
  logic           walk_step;
  logic           walk_done;
  logic [RES_BITS-1:0] trial;
  logic           conversion_run_bit;
  logic           comparator_enable_bit;
  logic [2:0]     time_code;

  assign conversion_run_bit    = converter_mode_control[RUN_POS];
  assign comparator_enable_bit = converter_mode_control[ENA_POS];
  assign time_code             = converter_mode_control[CODE_LSB+2:CODE_LSB];

  // Write merge shared by both registers
  function automatic logic [7:0] merge_wr(input logic [7:0] cur, input logic bitw,
                                          input logic [2:0] sel, input logic [7:0] wd,
                                          input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (bitw) v[sel] = wd[0];
    else      v = wd;
    merge_wr = v & mask;
  endfunction : merge_wr

  always_comb begin
    next_mode = converter_mode_control;
    next_chan = input_channel_select;
    reg_touch = 1'b0;
    if ((reg_wr || reg_bit_wr) && reg_addr == MODE_ADDR) begin
      next_mode = merge_wr(converter_mode_control, reg_bit_wr, reg_bit_sel,
                           reg_wdata, MODE_MASK);
      reg_touch = 1'b1;
    end
    if ((reg_wr || reg_bit_wr) && reg_addr == CHAN_ADDR) begin
      next_chan = merge_wr(input_channel_select, reg_bit_wr, reg_bit_sel,
                           reg_wdata, CHAN_MASK);
      reg_touch = 1'b1;
    end
  end

  // Read mux
  always_comb begin
    case (reg_addr)
      MODE_ADDR:     reg_rdata = converter_mode_control;
      CHAN_ADDR:     reg_rdata = input_channel_select;
      RES_LO_ADDR:   reg_rdata = result_wide[7:0];
      RES_HI_ADDR:   reg_rdata = result_wide[15:8];
      RES_BYTE_ADDR: reg_rdata = result_upper_byte;
      default:       reg_rdata = 8'h00;
    endcase
  end

  // Comparator answer comes from the analog side, so synchronise it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_high;
      cmp_sync <= cmp_meta;
    end
  end

  // Sequencer: cycle count within one conversion
  always_comb begin
    next_active   = active;
    next_cyc      = cyc;
    walk_start    = 1'b0;
    walk_step     = 1'b0;
    next_done_req = 1'b0;
    next_wide     = result_wide;
    next_upper    = result_upper_byte;
    if (reg_touch || !conversion_run_bit) begin
      // A register write abandons the walk; the new value restarts it
      next_active = 1'b0;
      next_cyc    = '0;
    end else if (!active) begin
      next_active = 1'b1;
      next_cyc    = '0;
    end else begin
      next_cyc = cyc + 8'd1;
      if (cyc + 8'd1 == amc_samp(time_code))
        walk_start = 1'b1;
      // Ten comparisons on the cycles just before total; the extra step at total finds no bit left
      if (cyc >= amc_samp(time_code) && cyc + 8'd1 < amc_total(time_code))
        walk_step = (amc_total(time_code) - cyc - 8'd1)
                    <= 8'(RES_BITS);
      if (cyc + 8'd1 == amc_total(time_code)) begin
        walk_step     = 1'b1;
        next_cyc      = '0;
        next_done_req = 1'b1;
      end
    end
    if (walk_done) begin
      next_wide  = {6'h00, trial};
      next_upper = trial[RES_BITS-1:RES_BITS-8];
    end
  end

  amc_sar #(
    .BITS(RES_BITS)
  ) u_sar (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clear      (!next_active),
    .begin_walk (walk_start),
    .step       (walk_step),
    .cmp_high   (cmp_sync),
    .trial      (trial),
    .walk_done  (walk_done)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      converter_mode_control  <= MODE_RESET;
      input_channel_select    <= CHAN_RESET;
      active                  <= 1'b0;
      cyc                     <= '0;
      result_wide             <= 16'h0000;
      result_upper_byte       <= 8'h00;
      conversion_done_request <= 1'b0;
    end else begin
      converter_mode_control  <= next_mode;
      input_channel_select    <= next_chan;
      active                  <= next_active;
      cyc                     <= next_cyc;
      result_wide             <= next_wide;
      result_upper_byte       <= next_upper;
      conversion_done_request <= next_done_req;
    end
  end

  // Mode decode
  always_comb begin
    if (conversion_run_bit)         op_state = AMC_CONV;
    else if (comparator_enable_bit) op_state = AMC_WAIT;
    else                            op_state = AMC_STOP;
  end

  // Comparator powered whenever running or enabled
  assign comparator_on = conversion_run_bit | comparator_enable_bit;
  assign sample_hold   = active && cyc < amc_samp(time_code);
  assign dac_trial     = trial;
  assign channel_code  = input_channel_select[1:0];

  chk_mode_reset: assert property (@(posedge clk_sys)
    $fell(rst) |-> converter_mode_control == 8'h00)
    else $error("mode register not cleared");
  chk_bit_write: assert property (@(posedge clk_sys) disable iff (rst)
    reg_bit_wr && reg_addr == MODE_ADDR && reg_bit_sel == 3'd0
    |=> converter_mode_control[7:1] == $past(converter_mode_control[7:1]))
    else $error("bit write disturbed other bits");
  chk_stop_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !conversion_run_bit |=> !active)
    else $error("sequencer running with run bit clear");
  chk_cmp_power: assert property (@(posedge clk_sys) disable iff (rst)
    op_state == AMC_STOP |-> !comparator_on)
    else $error("comparator powered while stopped");
  chk_start_noena: assert property (@(posedge clk_sys) disable iff (rst)
    conversion_run_bit && !comparator_enable_bit && !reg_touch && !active |=> active)
    else $error("conversion did not start");
  chk_done_time: assert property (@(posedge clk_sys) disable iff (rst)
    conversion_done_request |-> $past(cyc) + 8'd1 == amc_total(time_code))
    else $error("done at wrong cycle");
  chk_write_abort: assert property (@(posedge clk_sys) disable iff (rst)
    reg_touch |=> !active ##1 (active || !conversion_run_bit))
    else $error("write did not restart conversion");
  chk_result_load: assert property (@(posedge clk_sys) disable iff (rst)
    walk_done |=> result_wide == {6'h00, $past(trial)}
    && result_upper_byte == $past(trial[RES_BITS-1:RES_BITS-8]))
    else $error("result not loaded");
endmodule : amc_ctrl
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the converter mode control block
// Assumes: Comparator answer held steady through each conversion
// Notes:   Results are queued by the driver and checked as done pulses land
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amc_pkg::*;

  localparam logic [7:0] SAMP [8] = '{8'h0c, 8'h18, 8'h30, 8'h58, 8'h18, 8'h30, 8'h60, 8'hb0};
  localparam logic [7:0] TOTL [8] = '{8'h24, 8'h30, 8'h48, 8'h70, 8'h48, 8'h60, 8'h90, 8'he0};

  logic                 clk_sys     = 1'b0;
  logic                 rst         = 1'b1;
  logic [15:0]          reg_addr    = 16'h0000;
  logic                 reg_wr      = 1'b0;
  logic                 reg_bit_wr  = 1'b0;
  logic [2:0]           reg_bit_sel = 3'h0;
  logic [7:0]           reg_wdata   = 8'h00;
  logic                 cmp_high    = 1'b0;
  logic [7:0]           reg_rdata;
  logic [9:0]           dac_trial;
  logic                 sample_hold;
  logic                 comparator_on;
  logic [1:0]           channel_code;
  logic [15:0]          result_wide;
  logic [7:0]           result_upper_byte;
  logic                 conversion_done_request;
  amc_state_t           op_state;
  int                   errors      = 0;
  int                   checked     = 0;
  logic [9:0]           exp_q [$];
  logic [2:0]           done_d      = 3'h0;
  logic [9:0]           exp_res;

  always #5 clk_sys = ~clk_sys;

  amc_ctrl u_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmp_high(cmp_high), .dac_trial(dac_trial),
    .sample_hold(sample_hold), .comparator_on(comparator_on),
    .channel_code(channel_code), .result_wide(result_wide),
    .result_upper_byte(result_upper_byte),
    .conversion_done_request(conversion_done_request), .op_state(op_state)
  );

  task automatic report_and_stop;
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Results settle at most two edges after the pulse, so look three later
  always @(posedge clk_sys) begin
    done_d <= {done_d[1:0], conversion_done_request};
    if (done_d[2] === 1'b1) begin
      if (exp_q.size() == 0) check("unrequested done", 16'h0001, 16'h0000);
      else begin
        exp_res = exp_q.pop_front();
        check("result_wide", result_wide, {6'h00, exp_res});
        check("result_upper_byte", {8'h00, result_upper_byte}, {8'h00, exp_res[9:2]});
      end
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_bit_sel = s;
    reg_wdata = {7'h00, v};
    reg_bit_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_bit_wr = 1'b0;
  endtask : bw

  task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1 reg_addr = a;
    #1 check(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  // Counts cycles and sampling cycles up to the next done pulse
  task automatic wait_done(output int n, output int sh);
    n = 0;
    sh = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
      if (sample_hold === 1'b1) sh++;
      if (n > 1000) begin
        errors++;
        report_and_stop();
      end
    end while (conversion_done_request !== 1'b1);
  endtask : wait_done

  initial begin
    int n;
    int sh;
    int r;
    logic [7:0] v;
    logic [7:0] w;
    void'($urandom(42763));
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd("mode reset", MODE_ADDR, 8'h00);
    rd("chan reset", CHAN_ADDR, 8'h00);
    check("state reset", {14'h0000, op_state}, {14'h0000, AMC_STOP});
    v = 8'($urandom()) & 8'h39;
    wr(MODE_ADDR, v);
    rd("mode rw", MODE_ADDR, v & MODE_MASK);
    w = 8'($urandom());
    wr(CHAN_ADDR, w);
    rd("chan rw", CHAN_ADDR, w & CHAN_MASK);
    // Unmapped neighbour must neither store nor disturb
    wr(16'hff82, 8'hff);
    rd("unmapped", 16'hff82, 8'h00);
    rd("mode kept", MODE_ADDR, v & MODE_MASK);
    wr(MODE_ADDR, 8'h00);
    bw(MODE_ADDR, 3'h0, 1'b1);
    rd("bit set", MODE_ADDR, 8'h01);
    check("waiting", {14'h0000, op_state}, {14'h0000, AMC_WAIT});
    check("cmp on", {15'h0000, comparator_on}, 16'h0001);
    bw(MODE_ADDR, 3'h4, 1'b1);
    rd("bit only", MODE_ADDR, 8'h11);
    bw(MODE_ADDR, 3'h0, 1'b0);
    check("cmp off", {15'h0000, comparator_on}, 16'h0000);
    check("stopped", {14'h0000, op_state}, {14'h0000, AMC_STOP});
    wr(MODE_ADDR, 8'h00);
    // Every time code, comparator enable bit left clear, two back-to-back conversions
    // Analog settling limits lie outside this digital model
    for (int c = 0; c < 8; c++) begin
      cmp_high = 1'($urandom());
      wr(MODE_ADDR, {2'b00, 3'(c), 3'h0});
      repeat (2) @(posedge clk_sys);
      bw(MODE_ADDR, 3'h7, 1'b1);
      check("converting", {14'h0000, op_state}, {14'h0000, AMC_CONV});
      exp_q.push_back({10{cmp_high}});
      exp_q.push_back({10{cmp_high}});
      wait_done(n, sh);
      wait_done(n, sh);
      check("dac_trial", {6'h00, dac_trial}, {6'h00, {10{cmp_high}}});
      check("period", 16'(n), {8'h00, TOTL[c]});
      check("sampling", 16'(sh), {8'h00, SAMP[c]});
      rd("result low", RES_LO_ADDR, {8{cmp_high}});
      rd("result high", RES_HI_ADDR, {6'h00, {2{cmp_high}}});
      rd("result byte", RES_BYTE_ADDR, {8{cmp_high}});
      wr(MODE_ADDR, 8'h00);
    end
    // Channel write in mid-conversion must restart the count
    cmp_high = 1'($urandom());
    bw(MODE_ADDR, 3'h0, 1'b1);
    repeat (100) @(posedge clk_sys);
    bw(MODE_ADDR, 3'h7, 1'b1);
    exp_q.push_back({10{cmp_high}});
    wait_done(n, sh);
    repeat (20) @(posedge clk_sys);
    wr(CHAN_ADDR, 8'h01);
    exp_q.push_back({10{cmp_high}});
    wait_done(n, sh);
    check("abort restart", 16'(n), {8'h00, TOTL[0]} + 16'd1);
    check("channel", {14'h0000, channel_code}, 16'h0001);
    bw(MODE_ADDR, 3'h7, 1'b0);
    check("run cleared", {14'h0000, op_state}, {14'h0000, AMC_WAIT});
    r = 0;
    repeat (300) begin
      @(posedge clk_sys);
      #1 if (conversion_done_request === 1'b1) r++;
    end
    check("no done stopped", 16'(r), 16'h0000);
    // Reset while waiting with the comparator enabled clears both registers again
    wr(MODE_ADDR, 8'h29);
    @(posedge clk_sys);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd("mode re-reset", MODE_ADDR, 8'h00);
    rd("chan re-reset", CHAN_ADDR, 8'h00);
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
